//--- core/estop_pkg.sv
// Constants for the emergency-stop input monitor
package estop_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int START_HOLD_MS = 3000;
    localparam int START_HOLD_CYC = START_HOLD_MS * (CLK_HZ / 1000);
    localparam int DISC_MS = 250;
    localparam int DISC_CYC = DISC_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
    localparam int STARTUP_CYC = 16;
    localparam int BLINK_CYC = 62_500_000;
    localparam int NUM_IN = 8;
    localparam int NUM_START = 4;
    localparam logic [3:0] FUNC_MAX = 4'h7;
    localparam logic [3:0] SYS_ERR_CONFIG = 4'h5;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_INPUTS = 32'h0000_0008;
    localparam int CTRL_ACK_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int SC_PULSE_CYC = 64;
endpackage

//--- core/estop_input_monitor.sv
// Emergency-stop input monitor: input filtering, function select, start gating, status outputs
//
// Overview of operation
// R01: Green lamps only with all inputs and start
// R02: Signal contact never affects the enable
// R03: Signal contact present: lamp2 on, output2 off; outside run, output2 blinks or stays on in wait and fault instead
// R04: Signal contact absent: lamp2 off, output2 on; outside run, lamp2 stays on in wait and fault instead
// R05: Switch bank assigns start keys and outputs
// R06: Selector and switches read twice, compared
// R07: Functions 0/4: eight single-channel, auto/manual
// R08: Functions 1/5: six plus shorted two-channel
// R09: Functions 2/6: six plus two-channel or curtain
// R10: Functions 3/7: five, two-channel, signal contact
// R11: Selector 8 or 9 gives error 5
// R12: Shared sensor uses 2/3/6/7, external wiring
// R13: Single-channel inputs need potential-free contacts
// R14: Autostart only after power-up or stop
// R15: Other faults in autostart need start key
// R16: Operator releases start key within 3 s
// R17: Any assigned start key confirms start
// R18: Start key held over 3 s is fault
// R19: Two-channel disagreement over 250 ms is fault
// R20: Copy mismatch or invalid value gives error 5
// R21: System error latches everything off until power cycle
// R22: Outputs stay off until setting validated; run1 lamp and output1 follow the blink and start_assign shows the switch bank during the start-up count instead
// R23: Every contact synchronised and debounced before use; the short check on 6/7 also reads the synchronised, unfiltered copies
`timescale 1ns/1ns
module estop_input_monitor #(
    parameter int START_HOLD_CYC = estop_pkg::START_HOLD_CYC,
    parameter int DISC_CYC = estop_pkg::DISC_CYC,
    parameter int DEBOUNCE_CYC = estop_pkg::DEBOUNCE_CYC,
    parameter int BLINK_CYC = estop_pkg::BLINK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] contact_in,
    input wire logic [3:0] start_key_in,
    input wire logic [3:0] func_sel_a,
    input wire logic [3:0] func_sel_b,
    input wire logic [3:0] assign_sw_a,
    input wire logic [3:0] assign_sw_b,
    input wire logic ext_fault,
    output logic green_lamp,
    output logic enable_out,
    output logic run1_lamp,
    output logic run2_lamp,
    output logic status1_out,
    output logic status2_out,
    output logic sys_error,
    output logic [3:0] sys_err_code,
    output logic [3:0] start_assign
);
    typedef enum {ST_INIT, ST_WAIT_START, ST_RUN, ST_FAULT, ST_SYSERR} state_t;

    // Two-stage synchroniser then stable-count filter per contact
    logic [11:0] raw_s1_reg, raw_s2_reg, filt_reg, filt_next;
    logic [11:0] in_raw;
    logic [31:0] db_cnt_reg [12];
    logic [31:0] db_cnt_next [12];
    assign in_raw = {start_key_in, contact_in};

    always_comb begin
        filt_next = filt_reg;
        for (int i = 0; i < 12; i++) begin
            db_cnt_next[i] = db_cnt_reg[i];
            if (raw_s2_reg[i] == filt_reg[i]) begin
                db_cnt_next[i] = 32'h0;
            end else if (db_cnt_reg[i] >= 32'(DEBOUNCE_CYC - 1)) begin
                db_cnt_next[i] = 32'h0;
                filt_next[i] = raw_s2_reg[i]; // R23
            end else begin
                db_cnt_next[i] = db_cnt_reg[i] + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_s1_reg <= 12'h000;
            raw_s2_reg <= 12'h000;
            filt_reg <= 12'h000;
            for (int i = 0; i < 12; i++) db_cnt_reg[i] <= 32'h0;
        end else begin
            raw_s1_reg <= in_raw;
            raw_s2_reg <= raw_s1_reg; // R23
            filt_reg <= filt_next;
            for (int i = 0; i < 12; i++) db_cnt_reg[i] <= db_cnt_next[i];
        end
    end

    // Setting decode
    logic cfg_bad, manual, two_ch, sig_mode, shorted_chk;
    logic [7:0] safety_mask;
    logic [1:0] func_lo;
    logic [3:0] keys;
    logic all_ok, start_pressed, two_ch_agree, short_fault;
    assign cfg_bad = (func_sel_a != func_sel_b) || (assign_sw_a != assign_sw_b)
        || (func_sel_a > estop_pkg::FUNC_MAX); // R06 R11 R20
    assign manual = func_sel_a[2]; // R07 R08 R09 R10
    assign func_lo = func_sel_a[1:0];
    assign two_ch = func_lo != 2'h0; // R08 R09 R10
    assign shorted_chk = func_lo == 2'h1; // R08
    assign sig_mode = func_lo == 2'h3; // R10
    // Signal contact on input 5 excluded from the safety set
    assign safety_mask = sig_mode ? 8'hDF : 8'hFF; // R02
    assign keys = filt_reg[11:8] & assign_sw_a; // R05 R17
    assign start_pressed = |keys;
    assign two_ch_agree = filt_reg[6] == filt_reg[7];
    // Cross-wired channels read as equal high while the pair is treated as shorted pair
    assign short_fault = shorted_chk && filt_reg[6] && filt_reg[7] && (raw_s2_reg[6] != raw_s2_reg[7]);
    assign all_ok = &(filt_reg[7:0] | ~safety_mask);

    // Main sequencer
    state_t state_reg, state_next;
    logic [31:0] hold_cnt_reg, hold_cnt_next, disc_cnt_reg, disc_cnt_next;
    logic [7:0] boot_cnt_reg, boot_cnt_next;
    logic estop_trip_reg, estop_trip_next, first_reg, first_next;
    logic hold_err, disc_err;
    assign hold_err = hold_cnt_reg >= 32'(START_HOLD_CYC); // R16 R18
    assign disc_err = two_ch && (disc_cnt_reg >= 32'(DISC_CYC)); // R19

    always_comb begin
        state_next = state_reg;
        boot_cnt_next = boot_cnt_reg;
        estop_trip_next = estop_trip_reg;
        first_next = first_reg;
        hold_cnt_next = start_pressed ? hold_cnt_reg + 32'h1 : 32'h0;
        // Saturate only while the cause lasts, else the fault could never clear
        if (start_pressed && hold_err) hold_cnt_next = hold_cnt_reg;
        disc_cnt_next = (two_ch && !two_ch_agree) ? disc_cnt_reg + 32'h1 : 32'h0;
        if (disc_err && !two_ch_agree) disc_cnt_next = disc_cnt_reg;
        case (state_reg)
            ST_INIT: begin
                if (boot_cnt_reg < 8'(estop_pkg::STARTUP_CYC)) begin
                    boot_cnt_next = boot_cnt_reg + 8'h1; // R22
                end else if (cfg_bad) begin
                    state_next = ST_SYSERR;
                end else begin
                    state_next = ST_WAIT_START;
                end
            end
            ST_WAIT_START: begin
                if (all_ok && !disc_err && !short_fault) begin
                    // Autostart: power-up or after a stop, never after other faults
                    if (!manual && (first_reg || estop_trip_reg)) begin // R14
                        state_next = ST_RUN;
                    end else if (start_pressed && !hold_err && hold_cnt_reg != 32'h0) begin // R01 R17
                        state_next = ST_RUN;
                    end
                end
                if (hold_err || disc_err || short_fault) state_next = ST_FAULT; // R18
            end
            ST_RUN: begin
                first_next = 1'b0;
                estop_trip_next = 1'b0;
                if (disc_err || short_fault) begin
                    state_next = ST_FAULT; // R19
                end else if (!all_ok) begin
                    estop_trip_next = 1'b1;
                    state_next = ST_WAIT_START;
                end
            end
            ST_FAULT: begin
                first_next = 1'b0;
                estop_trip_next = 1'b0; // R15
                if (!start_pressed && !disc_err && !short_fault) state_next = ST_WAIT_START;
            end
            ST_SYSERR: state_next = ST_SYSERR; // R21
            default: state_next = ST_SYSERR;
        endcase
        if (state_reg != ST_INIT && (cfg_bad || ext_fault)) state_next = ST_SYSERR; // R20 R21
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_INIT;
            boot_cnt_reg <= 8'h00;
            hold_cnt_reg <= 32'h0;
            disc_cnt_reg <= 32'h0;
            estop_trip_reg <= 1'b0;
            first_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            boot_cnt_reg <= boot_cnt_next;
            hold_cnt_reg <= hold_cnt_next;
            disc_cnt_reg <= disc_cnt_next;
            estop_trip_reg <= estop_trip_next;
            first_reg <= first_next;
        end
    end

    // Sequencer checks
    property p_cfg_code;
        @(posedge pclk) disable iff (!presetn) state_reg == ST_INIT && boot_cnt_reg >= 8'(estop_pkg::STARTUP_CYC)
            && cfg_bad |=> sys_error && sys_err_code == estop_pkg::SYS_ERR_CONFIG;
    endproperty
    a_cfg_code: assert property (p_cfg_code) else $error("Bad setting did not raise error 5"); // R20
    property p_hold_fault;
        @(posedge pclk) disable iff (!presetn)
            state_reg == ST_WAIT_START && hold_err && !cfg_bad && !ext_fault |=> state_reg == ST_FAULT;
    endproperty
    a_hold_fault: assert property (p_hold_fault) else $error("Long key hold not flagged"); // R18
    property p_disc_off;
        @(posedge pclk) disable iff (!presetn) disc_err && state_reg != ST_INIT |=> !enable_out;
    endproperty
    a_disc_off: assert property (p_disc_off) else $error("Enable during channel disagreement"); // R19
    property p_auto_block;
        @(posedge pclk) disable iff (!presetn) state_reg == ST_WAIT_START && !manual && !first_reg
            && !estop_trip_reg && !start_pressed |=> !enable_out;
    endproperty
    a_auto_block: assert property (p_auto_block) else $error("Autostart after a non-stop fault"); // R15
    property p_manual_idle;
        @(posedge pclk) disable iff (!presetn) state_reg == ST_WAIT_START && manual && !start_pressed |=> !enable_out;
    endproperty
    a_manual_idle: assert property (p_manual_idle) else $error("Manual start without a key"); // R07
    property p_sig_free;
        @(posedge pclk) disable iff (!presetn) sig_mode && state_reg == ST_RUN && all_ok && !disc_err
            && !short_fault && !cfg_bad && !ext_fault |=> enable_out;
    endproperty
    a_sig_free: assert property (p_sig_free) else $error("Signal contact dropped the enable"); // R02

    // Output stage, all registered
    logic [31:0] blink_reg, blink_next;
    logic blink;
    logic run, syserr, wait_ok;
    logic green_next, en_next, r1_next, r2_next, s1_next, s2_next;
    logic [3:0] code_next, assign_next;
    assign blink = blink_reg >= 32'(BLINK_CYC / 2);
    assign run = state_next == ST_RUN;
    assign syserr = state_next == ST_SYSERR;
    assign wait_ok = state_next == ST_WAIT_START && all_ok;

    always_comb begin
        blink_next = (blink_reg >= 32'(BLINK_CYC - 1)) ? 32'h0 : blink_reg + 32'h1;
        green_next = run && !syserr; // R01 R21
        en_next = run; // R02 R22
        r1_next = run ? 1'b1 : (syserr ? 1'b0 : blink);
        s1_next = r1_next;
        if (syserr || state_next == ST_INIT) begin
            r2_next = 1'b0; // R21 R22
            s2_next = 1'b0;
        end else if (sig_mode && run) begin
            r2_next = filt_reg[5]; // R03 R04
            s2_next = !filt_reg[5]; // R03 R04
        end else begin
            r2_next = 1'b1;
            s2_next = run ? 1'b0 : (wait_ok ? blink : 1'b1);
        end
        code_next = syserr ? estop_pkg::SYS_ERR_CONFIG : 4'h0; // R11
        assign_next = syserr ? 4'h0 : assign_sw_a; // R05
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_reg <= 32'h0;
            green_lamp <= 1'b0;
            enable_out <= 1'b0;
            run1_lamp <= 1'b0;
            run2_lamp <= 1'b0;
            status1_out <= 1'b0;
            status2_out <= 1'b0;
            sys_error <= 1'b0;
            sys_err_code <= 4'h0;
            start_assign <= 4'h0;
        end else begin
            blink_reg <= blink_next;
            green_lamp <= green_next;
            enable_out <= en_next;
            run1_lamp <= r1_next;
            run2_lamp <= r2_next;
            status1_out <= s1_next;
            status2_out <= s2_next;
            sys_error <= syserr;
            sys_err_code <= code_next;
            start_assign <= assign_next;
        end
    end

    // Output checks; an error must hold for the four cycles after it is raised
    sequence s_err_enter;
        !sys_error ##1 sys_error;
    endsequence
    property p_err_hold;
        @(posedge pclk) disable iff (!presetn) s_err_enter |=> sys_error [*4];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("System error released early"); // R21
    property p_err_quiet;
        @(posedge pclk) disable iff (!presetn) sys_error |-> !enable_out && !green_lamp && !run1_lamp
            && !status1_out && start_assign == 4'h0;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("Output active during system error"); // R21
    property p_green_inputs;
        @(posedge pclk) disable iff (!presetn) green_lamp |-> $past(all_ok);
    endproperty
    a_green_inputs: assert property (p_green_inputs) else $error("Green lamp with an input missing"); // R01

    // APB slave: zero wait states; status read-only, unmapped gives error
    logic [31:0] rd_next;
    logic err_next;
    always_comb begin
        rd_next = 32'h0;
        err_next = 1'b0;
        case (paddr)
            estop_pkg::ADDR_CTRL: rd_next = {28'h0, func_sel_a};
            estop_pkg::ADDR_STATUS: rd_next = {24'h0, sys_err_code, 1'b0, sys_error, green_lamp, enable_out};
            estop_pkg::ADDR_INPUTS: rd_next = {20'h0, filt_reg};
            default: err_next = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && err_next;
            prdata <= (psel && !penable && !pwrite) ? rd_next : 32'h0;
        end
    end
endmodule // estop_input_monitor

//--- testbench/field_model.sv
// Field side model: contacts and start keys
`timescale 1ns/1ns
module field_model (
    input wire logic pclk,
    output logic [7:0] contact_in,
    output logic [3:0] start_key_in
);
    initial begin
        contact_in = 8'h00;
        start_key_in = 4'h0;
    end
    // Voltfree contacts only give clean levels
    task automatic set_contacts(input logic [7:0] v);
        @(posedge pclk);
        contact_in <= v;
    endtask
    // Keys are let go in time unless a long hold is asked for
    task automatic press(input int k, input int n);
        @(posedge pclk);
        start_key_in[k] <= 1'b1;
        repeat (n) @(posedge pclk);
        start_key_in[k] <= 1'b0;
    endtask
endmodule // field_model

//--- testbench/tb.sv
// Self-checking bench for the emergency-stop input monitor
`timescale 1ns/1ns
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_fault, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] contact_in;
    logic [3:0] start_key_in, func_sel_a, func_sel_b, assign_sw_a, assign_sw_b, sys_err_code, start_assign;
    logic green_lamp, enable_out, run1_lamp, run2_lamp, status1_out, status2_out, sys_error;
    logic [15:0] cfg [4] = '{16'h8833, 16'h9933, 16'h0133, 16'h0032};
    int fail_count = 0;
    int num_checks = 0;
    estop_input_monitor #(.START_HOLD_CYC(200), .DISC_CYC(50), .DEBOUNCE_CYC(2), .BLINK_CYC(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .contact_in(contact_in), .start_key_in(start_key_in), .func_sel_a(func_sel_a),
        .func_sel_b(func_sel_b), .assign_sw_a(assign_sw_a), .assign_sw_b(assign_sw_b),
        .ext_fault(ext_fault), .green_lamp(green_lamp), .enable_out(enable_out),
        .run1_lamp(run1_lamp), .run2_lamp(run2_lamp), .status1_out(status1_out),
        .status2_out(status2_out), .sys_error(sys_error), .sys_err_code(sys_err_code),
        .start_assign(start_assign));
    field_model fm (.pclk(pclk), .contact_in(contact_in), .start_key_in(start_key_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_en(input logic exp, input int n);
        for (int i = 0; i < n && enable_out !== exp; i++) @(posedge pclk);
    endtask
    // A fresh power-up per setting, since a setting change latches an error
    task automatic boot(input logic [3:0] fa, input logic [3:0] fb, input logic [3:0] sb, input logic [7:0] c);
        presetn <= 1'b0;
        func_sel_a <= fa;
        func_sel_b <= fb;
        assign_sw_b <= sb;
        fm.set_contacts(c);
        repeat (9) @(posedge pclk);
        chk("reset enable", 0, enable_out);
        presetn <= 1'b1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(8 * 40000);
        fail_count++;
        end_of_test();
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ext_fault = 1'b0;
        presetn = 1'b0;
        func_sel_a = 4'h0;
        func_sel_b = 4'h0;
        assign_sw_a = 4'h3;
        assign_sw_b = 4'h3;
        boot(4'h0, 4'h0, 4'h3, 8'hFF);
        wait_en(1'b1, 400);
        chk("enable", 1, enable_out);
        chk("green", 1, green_lamp);
        chk("run1 lamp", 1, run1_lamp);
        chk("out1", 1, status1_out);
        chk("assign", 3, start_assign);
        apb(1'b0, estop_pkg::ADDR_STATUS, 32'h0);
        chk("status", 3, rd[2:0]);
        apb(1'b1, estop_pkg::ADDR_CTRL, 32'h0000_000F);
        apb(1'b0, estop_pkg::ADDR_CTRL, 32'h0);
        chk("selector", 0, rd[3:0]);
        apb(1'b0, estop_pkg::ADDR_INPUTS, 32'h0);
        chk("inputs", 32'h0000_00FF, rd);
        apb(1'b0, 32'h0000_000C, 32'h0);
        chk("slverr", 1, err);
        fm.set_contacts(8'hFE);
        wait_en(1'b0, 100);
        chk("stop", 0, enable_out);
        chk("green off", 0, green_lamp);
        fm.set_contacts(8'hFF);
        wait_en(1'b1, 400);
        chk("restart", 1, enable_out);
        boot(4'h4, 4'h4, 4'h3, 8'hFF);
        repeat (100) @(posedge pclk);
        chk("manual idle", 0, enable_out);
        fm.press(3, 5);
        repeat (20) @(posedge pclk);
        chk("unassigned key", 0, enable_out);
        fm.press(1, 5);
        wait_en(1'b1, 50);
        chk("manual start", 1, enable_out);
        boot(4'h4, 4'h4, 4'h3, 8'hFE);
        fm.press(1, 300);
        fm.set_contacts(8'hFF);
        repeat (50) @(posedge pclk);
        chk("long hold", 0, enable_out);
        fm.press(0, 5);
        wait_en(1'b1, 50);
        chk("after hold", 1, enable_out);
        boot(4'h3, 4'h3, 4'h3, 8'hFF);
        wait_en(1'b1, 400);
        chk("lamp2 on", 1, run2_lamp);
        chk("out2 off", 0, status2_out);
        fm.set_contacts(8'hDF);
        repeat (20) @(posedge pclk);
        chk("lamp2 off", 0, run2_lamp);
        chk("out2 on", 1, status2_out);
        chk("sig enable", 1, enable_out);
        boot(4'h7, 4'h7, 4'h3, 8'hDF);
        repeat (100) @(posedge pclk);
        chk("func7 idle", 0, enable_out);
        fm.press(0, 5);
        wait_en(1'b1, 50);
        chk("func7 start", 1, enable_out);
        chk("func7 lamp2", 0, run2_lamp);
        chk("func7 out2", 1, status2_out);
        boot(4'h2, 4'h2, 4'h3, 8'hFF);
        wait_en(1'b1, 400);
        fm.set_contacts(8'h7F);
        repeat (100) @(posedge pclk);
        chk("disagree", 0, enable_out);
        fm.set_contacts(8'hFF);
        repeat (100) @(posedge pclk);
        chk("no autostart", 0, enable_out);
        fm.press(0, 5);
        wait_en(1'b1, 50);
        chk("confirmed", 1, enable_out);
        boot(4'h6, 4'h6, 4'h3, 8'hFF);
        repeat (100) @(posedge pclk);
        chk("func6 idle", 0, enable_out);
        fm.press(1, 5);
        wait_en(1'b1, 50);
        chk("func6 start", 1, enable_out);
        fm.set_contacts(8'h3F);
        wait_en(1'b0, 100);
        chk("curtain stop", 0, enable_out);
        boot(4'h5, 4'h5, 4'h3, 8'hFF);
        repeat (100) @(posedge pclk);
        chk("func5 idle", 0, enable_out);
        fm.press(0, 5);
        wait_en(1'b1, 50);
        chk("func5 start", 1, enable_out);
        fm.set_contacts(8'h7F);
        wait_en(1'b0, 100);
        chk("func5 stop", 0, enable_out);
        boot(4'h1, 4'h1, 4'h3, 8'hFF);
        wait_en(1'b1, 400);
        chk("func1 auto", 1, enable_out);
        foreach (cfg[i]) begin
            assign_sw_a <= cfg[i][7:4];
            boot(cfg[i][15:12], cfg[i][11:8], cfg[i][3:0], 8'hFF);
            repeat (100) @(posedge pclk);
            chk("cfg error", 1, sys_error);
            chk("cfg code", estop_pkg::SYS_ERR_CONFIG, sys_err_code);
            chk("cfg enable", 0, enable_out);
            chk("cfg run1", 0, run1_lamp);
        end
        assign_sw_a <= 4'h3;
        boot(4'h0, 4'h0, 4'h3, 8'hFF);
        wait_en(1'b1, 400);
        ext_fault <= 1'b1;
        repeat (10) @(posedge pclk);
        ext_fault <= 1'b0;
        repeat (50) @(posedge pclk);
        chk("latched", 1, sys_error);
        chk("latched green", 0, green_lamp);
        chk("latched enable", 0, enable_out);
        chk("latched run1", 0, run1_lamp);
        chk("latched out1", 0, status1_out);
        chk("latched out2", 0, status2_out);
        chk("latched assign", 0, start_assign);
        apb(1'b0, estop_pkg::ADDR_STATUS, 32'h0);
        chk("status err", 4, rd[2:0]);
        end_of_test();
    end
endmodule // tb
